// ===== bench/core_side.sv
/* Model of the core side: watchdog oscillator and clear instruction.
   Assumes kick is driven on the core clock by the bench. */
`timescale 1ns/10ps
`default_nettype none
module core_side (
	input  wire logic core_clk,
	input  wire logic kick,
	output var logic  dog_osc,
	output var logic  dog_clear_instruction
);
	logic [1:0] div_r;
	initial begin
		div_r = 2'h0;
		dog_osc = 1'b0;
		dog_clear_instruction = 1'b0;
	end
	// free oscillator, one-cycle clear
	// Four core cycles per tick: two-cycle levels still pass the two-stage
	// sync, and the shortest period expires inside the cycle budget
	always @(posedge core_clk) begin
		div_r <= div_r + 2'h1;
		if (div_r[0])
			dog_osc <= !dog_osc;
		dog_clear_instruction <= kick;
	end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
/* Self-checking bench for the watchdog and reset-flag block.
   Assumes the package is compiled first; delays shortened to 4..16. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic core_clk, rst_b, psel, penable, pwrite, pin_reset_b;
	logic brownout_det, scan_reset, kick, dog_osc, dog_clr, e;
	logic dog_reset_pulse, core_reset_b, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, seed;
	int failures, n_compared;
	int bitpos[3] = '{1, 2, 4};
	watchdog_and_reset_flags #(.DELAY_CYC0(4), .DELAY_CYC1(8),
		.DELAY_CYC2(12), .DELAY_CYC3(16)) dut (.core_clk, .rst_b, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.dog_clear_instruction(dog_clr), .dog_osc, .pin_reset_b,
		.brownout_det, .scan_reset, .clock_select_fuses(2'h1),
		.dog_reset_pulse, .core_reset_b);
	core_side partner (.core_clk, .kick, .dog_osc,
		.dog_clear_instruction(dog_clr));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Waits for the pulse (w=1) or the core leaving reset (w=0)
	task automatic wait_until(input bit w, input int lim);
		int i;
		i = 0;
		while ((w ? dog_reset_pulse : core_reset_b) !== 1'b1 && i < lim) begin
			@(posedge core_clk);
			i++;
		end
		if (i == lim) begin
			failures++;
			report_and_stop();
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			failures++;
			report_and_stop();
		end
	endtask
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = !core_clk;
	end
	initial begin
		{rst_b, psel, penable, pwrite, brownout_det, scan_reset, kick} = 0;
		pin_reset_b = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		seed = 32'h333f;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		wait_until(0, 100);
		// read then clear the flags early
		apb(0, wdt_pkg::FLAGS_ADDR, 0); chk("flags", q, 32'h0000_0001);
		apb(0, wdt_pkg::CTRL_ADDR, 0); chk("ctrl", q, 32'h0000_0000);
		apb(0, 8'h08, 0); chk("err", {q[30:0], e}, 32'h0000_0001);
		apb(1, wdt_pkg::FLAGS_ADDR, 32'hFFFF_FFFF);
		apb(0, wdt_pkg::FLAGS_ADDR, 0); chk("flags", q, 32'h0000_0001);
		apb(1, wdt_pkg::FLAGS_ADDR, 0);
		apb(0, wdt_pkg::FLAGS_ADDR, 0); chk("flags", q, 32'h0000_0000);
		$display("test registers done");
		for (int k = 0; k < 3; k++) begin
			@(posedge core_clk);
			pin_reset_b <= (k != 0);
			brownout_det <= (k == 1);
			scan_reset <= (k == 2);
			repeat (6) @(posedge core_clk);
			pin_reset_b <= 1'b1;
			brownout_det <= 1'b0;
			scan_reset <= 1'b0;
			wait_until(0, 200);
			apb(0, wdt_pkg::FLAGS_ADDR, 0);
			chk("src flag", q, 32'h1 << bitpos[k]);
			apb(1, wdt_pkg::FLAGS_ADDR, 0);
		end
		$display("test sources done");
		seed = lfsr(seed);
		apb(1, wdt_pkg::CTRL_ADDR, {seed[31:8], 8'hEF});
		apb(0, wdt_pkg::CTRL_ADDR, 0); chk("ctrl", q, 32'h0000_000F);
		apb(1, wdt_pkg::CTRL_ADDR, 32'h0000_0007);
		apb(0, wdt_pkg::CTRL_ADDR, 0); chk("ctrl", q, 32'h0000_000F);
		// unlock then disable inside the window
		apb(1, wdt_pkg::CTRL_ADDR, 32'h0000_0018);
		apb(1, wdt_pkg::CTRL_ADDR, 32'h0000_0000);
		apb(0, wdt_pkg::CTRL_ADDR, 0); chk("ctrl", q, 32'h0000_0000);
		apb(1, wdt_pkg::CTRL_ADDR, 32'h0000_0010);
		repeat (6) @(posedge core_clk);
		apb(1, wdt_pkg::CTRL_ADDR, 32'h0000_0008);
		apb(1, wdt_pkg::CTRL_ADDR, 32'h0000_0000);
		apb(0, wdt_pkg::CTRL_ADDR, 0); chk("ctrl", q, 32'h0000_0008);
		$display("test control done");
		@(posedge core_clk);
		kick <= 1'b1;
		@(posedge core_clk);
		kick <= 1'b0;
		wait_until(1, 70000);
		wait_until(0, 200);
		apb(0, wdt_pkg::FLAGS_ADDR, 0); chk("dog flag", q, 32'h0000_0008);
		apb(0, wdt_pkg::CTRL_ADDR, 0); chk("ctrl", q, 32'h0000_0000);
		$display("test expiry done");
		report_and_stop();
	end
endmodule
bind watchdog_and_reset_flags wdt_properties props (.core_clk, .rst_b,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
	.pin_reset_b, .brownout_det, .dog_reset_pulse, .core_reset_b);
`default_nettype wire

// ===== bench/wdt_properties.sv
/* Port checker for the watchdog and reset-flag block.
   Assumes binding onto the top module; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module wdt_properties (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        pin_reset_b,
	input wire logic        brownout_det,
	input wire logic        dog_reset_pulse,
	input wire logic        core_reset_b
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire mapped = paddr == 8'h00 || paddr == 8'h04;
	pulse_one_a: assert property (dog_reset_pulse |=> !dog_reset_pulse)
		else $error("reset pulse longer than one cycle");
	pulse_hold_a: assert property (dog_reset_pulse |-> ##[1:2] !core_reset_b)
		else $error("core not held after pulse");
	pulse_quiet_a: assert property (dog_reset_pulse |-> core_reset_b)
		else $error("pulse during another reset");
	pin_hold_a: assert property (!pin_reset_b [*4] |-> !core_reset_b)
		else $error("pin reset not held");
	brown_hold_a: assert property (brownout_det [*4] |-> !core_reset_b)
		else $error("brownout reset not held");
	ctrl_rsvd_a: assert property (pready && !pwrite && paddr == 8'h04
		|-> prdata[31:5] == 27'h0)
		else $error("reserved control bits nonzero");
	flag_width_a: assert property (pready && !pwrite && paddr == 8'h00
		|-> prdata[31:5] == 27'h0)
		else $error("flag read wider than five bits");
	ready_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after one wait state");
	ready_one_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	err_map_a: assert property (pready |-> pslverr == !mapped)
		else $error("error flag wrong for address");
endmodule
`default_nettype wire

// ===== rtl/watchdog_and_reset_flags.sv
/*
 * Watchdog timer with reset-delay counter and reset-cause flag register.
 * Assumes an APB master on core_clk, rst_b acting as the power-on reset,
 * a free running watchdog oscillator and reset sources arriving async.
 */
//
// Summary of operation
// - On expiry a reset pulse lasting exactly one system clock is emitted.
// - Falling edge of that pulse starts the reset delay counter.
// - Watchdog counter advances on its own oscillator, not the system clock.
// - Clear instruction restarts the watchdog counter from zero.
// - Counter also cleared while disabled and during any chip reset.
// - Unserviced expiry resets the device, restarting from reset vector.
// - Three-bit select picks 16384 to 2097152 oscillator cycles, doubling.
// - Turn-off unlock bit clears itself four system clocks after set.
// - Writing one enables; writing zero disables only while unlock reads one.
// - Control bits 7 to 5 always read as zero.
// - Scan reset sets flag 4; power-on or software zero clears it.
// - Watchdog reset sets flag 3; power-on or software zero clears it.
// - Brown-out reset sets flag 2; power-on or software zero clears it.
// - Pin reset sets flag 1; power-on or software zero clears it.
// - Power-on sets flag 0; only a software zero clears it.
// - Delay counter length selected by nonvolatile clock-select fuses.
`timescale 1ns/10ps
`default_nettype none

module watchdog_and_reset_flags #(
	parameter int unsigned DELAY_CYC0 = wdt_pkg::TOUT0_CYC,
	parameter int unsigned DELAY_CYC1 = wdt_pkg::TOUT1_CYC,
	parameter int unsigned DELAY_CYC2 = wdt_pkg::TOUT2_CYC,
	parameter int unsigned DELAY_CYC3 = wdt_pkg::TOUT3_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        dog_clear_instruction,
	input  wire logic        dog_osc,
	input  wire logic        pin_reset_b,
	input  wire logic        brownout_det,
	input  wire logic        scan_reset,
	input  wire logic [1:0]  clock_select_fuses,
	output logic             dog_reset_pulse,
	output logic             core_reset_b
);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	wire logic [5:0] sync_in;
	logic      [5:0] sync1_r;
	logic      [5:0] sync2_r;

	assign sync_in = {clock_select_fuses, scan_reset, brownout_det,
	                  pin_reset_b, dog_osc};

	genvar gi;
	generate
		for (gi = 0; gi < wdt_pkg::SYNC_W; gi++) begin : g_sync
			always_ff @(posedge core_clk) begin
				if (!rst_b) begin
					sync1_r[gi] <= wdt_pkg::SYNC_RST[gi];
					sync2_r[gi] <= wdt_pkg::SYNC_RST[gi];
				end else begin
					sync1_r[gi] <= sync_in[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	wire logic       osc_s;
	wire logic       pin_rst;
	wire logic       brownout_rst;
	wire logic       scan_rst;
	wire logic [1:0] fuse_s;
	logic            osc_d_r;

	assign osc_s        = sync2_r[0];
	assign pin_rst      = ~sync2_r[1];
	assign brownout_rst = sync2_r[2];
	assign scan_rst     = sync2_r[3];
	assign fuse_s       = sync2_r[5:4];

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			osc_d_r <= 1'b0;
		else
			osc_d_r <= osc_s;
	end

	wire logic osc_tick;
	assign osc_tick = osc_s & ~osc_d_r;

	////////////////////////////////////////////////////////////////////////
	// APB decode

	wire logic sel_flags;
	wire logic sel_ctrl;
	wire logic mapped;
	wire logic access;
	wire logic flags_wr;
	wire logic ctrl_wr;

	assign sel_flags = (paddr == wdt_pkg::FLAGS_ADDR);
	assign sel_ctrl  = (paddr == wdt_pkg::CTRL_ADDR);
	assign mapped    = sel_flags | sel_ctrl;
	// Transfer completes on the second access cycle
	assign access    = psel & penable & pready;
	assign flags_wr  = access & pwrite & sel_flags;
	assign ctrl_wr   = access & pwrite & sel_ctrl;

	////////////////////////////////////////////////////////////////////////
	// Watchdog control register

	wdt_pkg::ctrl_t  ctrl_r;
	wdt_pkg::ctrl_t  ctrl_nxt;
	logic      [2:0] unl_cnt_r;
	logic      [2:0] unl_cnt_nxt;
	logic            dog_pulse_r;
	wire logic       chip_rst;

	// any source but power-on (rst_b), including the watchdog itself
	assign chip_rst = pin_rst | brownout_rst | scan_rst | dog_pulse_r;

	always_comb begin
		ctrl_nxt    = ctrl_r;
		unl_cnt_nxt = unl_cnt_r;
		if (ctrl_wr && pwdata[wdt_pkg::UNLOCK_BIT]) begin
			ctrl_nxt.unlock = 1'b1;
			unl_cnt_nxt     = wdt_pkg::UNLOCK_CYC - 3'h1;
		end else if (ctrl_r.unlock) begin
			if (unl_cnt_r == 3'h0)
				ctrl_nxt.unlock = 1'b0;
			else
				unl_cnt_nxt = unl_cnt_r - 3'h1;
		end
		if (ctrl_wr) begin
			// a zero only lands while unlock is already set
			ctrl_nxt.enable = pwdata[wdt_pkg::ENABLE_BIT] |
			                  (ctrl_r.enable & ~ctrl_r.unlock);
			ctrl_nxt.sel    = pwdata[wdt_pkg::SEL_LSB +: 3];
		end
		ctrl_nxt.rsvd = 3'h0;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b || chip_rst) begin
			ctrl_r    <= wdt_pkg::CTRL_RST;
			unl_cnt_r <= 3'h0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			unl_cnt_r <= unl_cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog counter

	logic      [20:0] dog_cnt_r;
	logic      [20:0] dog_cnt_nxt;
	wire logic [21:0] period;
	wire logic [20:0] dog_limit;
	wire logic        expire;

	assign period    = wdt_pkg::BASE_PERIOD << ctrl_r.sel;
	assign dog_limit = 21'(period - 22'h00_0001);
	assign expire    = ctrl_r.enable & osc_tick & (dog_cnt_r == dog_limit);

	always_comb begin
		dog_cnt_nxt = dog_cnt_r;
		// cleared when disabled or in reset
		if (chip_rst || dog_clear_instruction || !ctrl_r.enable)
			dog_cnt_nxt = 21'h00_0000;
		else if (osc_tick)
			dog_cnt_nxt = expire ? 21'h00_0000 : dog_cnt_r + 21'h00_0001;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			dog_cnt_r   <= 21'h00_0000;
			dog_pulse_r <= 1'b0;
		end else begin
			dog_cnt_r   <= dog_cnt_nxt;
			// counter restarts, so the pulse is one clock
			dog_pulse_r <= expire & ~chip_rst;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset delay counter

	wire logic [23:0] delay_last;
	logic      [23:0] dly_cnt_r;
	logic             core_run_r;

	assign delay_last = (fuse_s == 2'h0) ? 24'(DELAY_CYC0 - 1) :
	                    (fuse_s == 2'h1) ? 24'(DELAY_CYC1 - 1) :
	                    (fuse_s == 2'h2) ? 24'(DELAY_CYC2 - 1) :
	                                       24'(DELAY_CYC3 - 1);

	// count starts once the pulse falls
	always_ff @(posedge core_clk) begin
		if (!rst_b || chip_rst) begin
			dly_cnt_r  <= 24'h00_0000;
			core_run_r <= 1'b0;
		end else if (!core_run_r) begin
			if (dly_cnt_r == delay_last)
				core_run_r <= 1'b1;
			else
				dly_cnt_r <= dly_cnt_r + 24'h00_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset-cause flags

	wdt_pkg::flags_t flags_r;
	wire logic [4:0] flag_set;
	wire logic [4:0] flag_clr;

	assign flag_set = {scan_rst, dog_pulse_r, brownout_rst, pin_rst, 1'b0};
	assign flag_clr = flags_wr ? ~pwdata[4:0] : 5'h00;

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			// power-on sets flag 0, clears the rest
			flags_r <= wdt_pkg::FLAGS_RST;
		else
			// Set wins over a same-cycle software clear
			flags_r <= flag_set | (flags_r & ~flag_clr);
	end

	////////////////////////////////////////////////////////////////////////
	// APB response

	wire logic [31:0] rd_mux;
	logic      [31:0] prdata_r;
	logic             pready_r;
	logic             pslverr_r;

	assign rd_mux = sel_flags ? {27'h000_0000, flags_r} :
	                sel_ctrl  ? {24'h00_0000, ctrl_r}   : 32'h0000_0000;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= psel & penable & ~pready_r;
			pslverr_r <= psel & penable & ~pready_r & ~mapped;
			prdata_r  <= (psel & penable & ~pready_r & ~pwrite) ?
			             rd_mux : 32'h0000_0000;
		end
	end

	assign prdata          = prdata_r;
	assign pready          = pready_r;
	assign pslverr         = pslverr_r;
	assign dog_reset_pulse = dog_pulse_r;
	assign core_reset_b    = core_run_r;

endmodule

`default_nettype wire

// ===== rtl/wdt_pkg.sv
/*
 * Constants and carrier types for the watchdog and reset-cause flag block.
 * Assumes a 25 MHz system clock and an APB register bus with 32-bit data.
 */
package wdt_pkg;

	// Register byte addresses
	localparam logic [7:0]  FLAGS_ADDR      = 8'h00;
	localparam logic [7:0]  CTRL_ADDR       = 8'h04;

	// Reset-cause flag positions
	localparam int          POWERON_BIT     = 0;
	localparam int          PIN_BIT         = 1;
	localparam int          BROWNOUT_BIT    = 2;
	localparam int          DOG_BIT         = 3;
	localparam int          SCAN_BIT        = 4;

	// Watchdog control field positions
	localparam int          SEL_LSB         = 0;
	localparam int          ENABLE_BIT      = 3;
	localparam int          UNLOCK_BIT      = 4;

	// Reset values
	localparam logic [4:0]  FLAGS_RST       = 5'h01;
	localparam logic [7:0]  CTRL_RST        = 8'h00;

	// Synchroniser order: osc, pin_b, brownout, scan, fuse0, fuse1
	localparam int          SYNC_W          = 6;
	localparam logic [5:0]  SYNC_RST        = 6'h02;

	// Timing
	localparam logic [2:0]  UNLOCK_CYC      = 3'h4;
	localparam logic [21:0] BASE_PERIOD     = 22'h00_4000;
	localparam int          CLK_MHZ         = 25;
	localparam int          TOUT0_US        = 10;
	localparam int          TOUT1_US        = 4100;
	localparam int          TOUT2_US        = 16000;
	localparam int          TOUT3_US        = 65000;
	localparam int          TOUT0_CYC       = TOUT0_US * CLK_MHZ;
	localparam int          TOUT1_CYC       = TOUT1_US * CLK_MHZ;
	localparam int          TOUT2_CYC       = TOUT2_US * CLK_MHZ;
	localparam int          TOUT3_CYC       = TOUT3_US * CLK_MHZ;

	typedef struct packed {
		logic [2:0] rsvd;
		logic       unlock;
		logic       enable;
		logic [2:0] sel;
	} ctrl_t;

	typedef struct packed {
		logic scan;
		logic dog;
		logic brownout;
		logic pin;
		logic poweron;
	} flags_t;

endpackage
